// ==== core/sdram_ctrl.sv ====
// multiport sdram controller core with axi4-lite register port
// Contract
// - commands for ddr2, ddr3, lpddr2
// - row/bank/column cover 4 Gb parts
// - ecc over 24 or 40 bit words
// - memory width 8,16,16e,32,32e
// - look-ahead reorders commands, banks prepared early; the core prepares a bank only for the command it has picked
// - read data returns out of order
// - per-port closed or open page policy
// - absolute priority, then weight among equals
// - self refresh, pasr, power down, dpd
// - group reads and writes together
// - many host ports into one controller
// - processor port 64-bit
// - interconnect port 32-bit
// - register port sets timing, power, status
// - fabric command, read data, write data
// - six fabric command ports
// - fabric port role axi read/write or native
// - fabric widths 32, 64, 128, 256
// - convert host transactions to sdram sequences
// - wide fabric ports use several data ports
// - full command buffer drops ready
// - fabric ports arrive in the core clock, no synchronisation inside the core
`timescale 1ns/1ps
module sdram_ctrl #(
	parameter int NPORT = sdram_pkg::NPORT
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// axi4-lite register port
	input wire logic [7:0] S_AWADDR,
	input wire logic S_AWVALID,
	output logic S_AWREADY,
	input wire logic [31:0] S_WDATA,
	input wire logic [3:0] S_WSTRB,
	input wire logic S_WVALID,
	output logic S_WREADY,
	output logic [1:0] S_BRESP,
	output logic S_BVALID,
	input wire logic S_BREADY,
	input wire logic [7:0] S_ARADDR,
	input wire logic S_ARVALID,
	output logic S_ARREADY,
	output logic [31:0] S_RDATA,
	output logic [1:0] S_RRESP,
	output logic S_RVALID,
	input wire logic S_RREADY,
	// host command ports: 0 processor, 1 interconnect, 2..7 fabric
	input wire logic [NPORT-1:0] HOST_VALID,
	input sdram_pkg::host_req_t [NPORT-1:0] HOST_REQ,
	output logic [NPORT-1:0] HOST_READY,
	output logic [NPORT-1:0] HOST_WACK,
	output logic [NPORT-1:0] HOST_RVALID,
	output logic [NPORT-1:0][63:0] HOST_RDATA,
	// phy side
	output sdram_pkg::mem_cmd_t MEM_CMD,
	output logic [31:0] MEM_WDATA,
	output logic [7:0] MEM_WECC,
	input wire logic MEM_RVALID,
	input wire logic [2:0] MEM_RTAG,
	input wire logic [31:0] MEM_RDATA,
	input wire logic [7:0] MEM_RECC
);
	typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_PRE = 3'b001, ST_ACT = 3'b010,
		ST_RW = 3'b011, ST_PREA = 3'b100, ST_LOWP = 3'b101} st_t;

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] r_ctrl, r_timing, r_power, r_porten, r_prio, r_weight, r_fab;
	logic ecc_err; // sticky, write one to clear
	logic aw_have, w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	st_t st;
	logic cfg_err;
	logic [NPORT-1:0] slot_v, wait_rd;

	sdram_pkg::mem_type_t mtype;
	sdram_pkg::wmode_t wmode;
	sdram_pkg::pwr_t preq;
	assign mtype = sdram_pkg::mem_type_t'(r_ctrl[1:0]);
	assign wmode = sdram_pkg::wmode_t'(r_ctrl[sdram_pkg::CTRL_WMODE +: 3]);
	assign preq = sdram_pkg::pwr_t'(r_power[2:0]);

	// address and data channels taken independently, held until both present
	assign S_AWREADY = !aw_have;
	assign S_WREADY = !w_have;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			S_BVALID <= 1'b0;
			S_BRESP <= 2'b00;
		end else begin
			if (S_AWVALID && !aw_have) begin
				aw_have <= 1'b1;
				aw_addr <= S_AWADDR;
			end
			if (S_WVALID && !w_have) begin
				w_have <= 1'b1;
				w_data <= S_WDATA;
			end
			if (aw_have && w_have && !S_BVALID) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				S_BVALID <= 1'b1;
				// unmapped word or the status word answers decode error
				S_BRESP <= (aw_addr[7:2] > sdram_pkg::REG_FABCFG[7:2]) ? sdram_pkg::RESP_DECERR : 2'b00;
			end else if (S_BREADY) begin
				S_BVALID <= 1'b0;
			end
		end
	end
	wire reg_wr = aw_have && w_have && !S_BVALID;

	// software configuration: timing, power request, port setup
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			r_ctrl <= sdram_pkg::RST_CTRL;
			r_timing <= sdram_pkg::RST_TIMING;
			r_power <= 32'h0000_0000;
			r_porten <= sdram_pkg::RST_PORTEN;
			r_prio <= 32'h0000_0000;
			r_weight <= 32'h0000_0000;
			r_fab <= 32'h0000_0000;
		end else if (reg_wr && S_WSTRB != 4'h0) begin
			case ({aw_addr[7:2], 2'b00})
				sdram_pkg::REG_CTRL: r_ctrl <= w_data;
				sdram_pkg::REG_TIMING: r_timing <= w_data;
				sdram_pkg::REG_POWER: r_power <= w_data;
				sdram_pkg::REG_PORTEN: r_porten <= w_data;
				sdram_pkg::REG_PRIO: r_prio <= w_data;
				sdram_pkg::REG_WEIGHT: r_weight <= w_data;
				sdram_pkg::REG_FABCFG: r_fab <= w_data;
				default: r_ctrl <= r_ctrl;
			endcase
		end
	end

	// read channel answers one cycle after the address is taken
	assign S_ARREADY = !S_RVALID;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			S_RVALID <= 1'b0;
			S_RDATA <= 32'h0000_0000;
			S_RRESP <= 2'b00;
		end else if (S_ARVALID && !S_RVALID) begin
			S_RVALID <= 1'b1;
			S_RRESP <= 2'b00;
			case ({S_ARADDR[7:2], 2'b00})
				sdram_pkg::REG_CTRL: S_RDATA <= r_ctrl;
				sdram_pkg::REG_TIMING: S_RDATA <= r_timing;
				sdram_pkg::REG_POWER: S_RDATA <= r_power;
				sdram_pkg::REG_PORTEN: S_RDATA <= r_porten;
				sdram_pkg::REG_PRIO: S_RDATA <= r_prio;
				sdram_pkg::REG_WEIGHT: S_RDATA <= r_weight;
				sdram_pkg::REG_FABCFG: S_RDATA <= r_fab;
				sdram_pkg::REG_STATUS: S_RDATA <= {11'h000, ecc_err, cfg_err, st,
					wait_rd, slot_v};
				default: begin
					S_RDATA <= 32'h0000_0000;
					S_RRESP <= sdram_pkg::RESP_DECERR;
				end
			endcase
		end else if (S_RREADY) begin
			S_RVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fabric data port budget: each data port is 64 bits wide
	logic [3:0] rd_ports, wr_ports;
	always_comb begin
		logic [2:0] n;
		logic [1:0] role;
		n = 3'd0;
		role = 2'd0;
		rd_ports = 4'd0;
		wr_ports = 4'd0;
		for (int f = 0; f < sdram_pkg::NFAB; f++) begin
			// width code 0..3 means 32, 64, 128, 256 bits
			n = (r_fab[2*f +: 2] == 2'd3) ? 3'd4 : (r_fab[2*f +: 2] == 2'd2) ? 3'd2 : 3'd1;
			// role 0 native both ways, 1 axi read channel, 2 axi write channel
			role = r_fab[sdram_pkg::FAB_ROLE + 2*f +: 2];
			if (r_porten[sdram_pkg::FAB_BASE + f]) begin
				if (role != 2'd2) rd_ports = rd_ports + 4'(n);
				if (role != 2'd1) wr_ports = wr_ports + 4'(n);
			end
		end
		cfg_err = (rd_ports > 4'(sdram_pkg::DATA_PORTS)) || (wr_ports > 4'(sdram_pkg::DATA_PORTS));
	end

	// a port is live when enabled; overbooked fabric set refuses all fabric
	logic [NPORT-1:0] port_ok, dir_ok;
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			port_ok[i] = r_porten[i] && (i < sdram_pkg::FAB_BASE || !cfg_err);
			dir_ok[i] = 1'b1;
			// axi channel ports accept only their own direction
			if (i >= sdram_pkg::FAB_BASE) begin
				case (r_fab[sdram_pkg::FAB_ROLE + 2*(i - sdram_pkg::FAB_BASE) +: 2])
					2'd1: dir_ok[i] = !HOST_REQ[i].we;
					2'd2: dir_ok[i] = HOST_REQ[i].we;
					default: dir_ok[i] = 1'b1;
				endcase
			end
		end
	end

	// one command slot per port; full slot drops ready
	assign HOST_READY = port_ok & dir_ok & ~slot_v & ~wait_rd;

	////////////////////////////////////////////////////////////////////////////
	// bank state per rank for look-ahead
	logic [15:0] open_row [2][8];
	logic [1:0][7:0] bank_open;
	sdram_pkg::host_req_t slot_q [NPORT];
	logic [NPORT-1:0] hit;
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			hit[i] = bank_open[slot_q[i].addr[sdram_pkg::CS_BIT]][slot_q[i].addr[sdram_pkg::BANK_LSB +: 3]]
				&& open_row[slot_q[i].addr[sdram_pkg::CS_BIT]][slot_q[i].addr[sdram_pkg::BANK_LSB +: 3]]
				== slot_q[i].addr[sdram_pkg::ROW_LSB +: 16];
		end
	end

	// score: priority first, then same direction, then row hit
	logic last_we;
	logic [2:0] rr, sel;
	logic any;
	always_comb begin
		logic [4:0] best, sc;
		logic [2:0] k;
		best = 5'd0;
		sc = 5'd0;
		k = 3'd0;
		sel = 3'd0;
		any = 1'b0;
		for (int j = 0; j < NPORT; j++) begin
			k = rr + 3'(j);
			sc = {r_prio[3*k +: 3], slot_q[k].we == last_we, hit[k]};
			if (slot_v[k] && (!any || sc > best)) begin
				any = 1'b1;
				best = sc;
				sel = k;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command sequencer
	logic [2:0] cur;
	logic [3:0] gap, wcnt;
	logic lowp_in; // entry command already sent during this low power stay
	sdram_pkg::mem_cmd_t next_cmd;
	wire cur_cs = slot_q[cur].addr[sdram_pkg::CS_BIT];
	wire [2:0] cur_bank = slot_q[cur].addr[sdram_pkg::BANK_LSB +: 3];
	wire [15:0] cur_row = slot_q[cur].addr[sdram_pkg::ROW_LSB +: 16];
	wire pw_allowed = preq != sdram_pkg::PW_NONE && (preq != sdram_pkg::PW_DPD || mtype == sdram_pkg::MEM_LPDDR2);
	wire go = gap == 4'd0;

	// next command for the phy; each command kind names the memory type
	always_comb begin
		next_cmd = '0;
		next_cmd.mtype = mtype;
		next_cmd.cs_n = 2'b11;
		next_cmd.tag = cur;
		if (go) begin
			case (st)
				ST_PRE: next_cmd.cmd = sdram_pkg::C_PRE;
				ST_ACT: next_cmd.cmd = sdram_pkg::C_ACT;
				ST_RW: next_cmd.cmd = slot_q[cur].we ? sdram_pkg::C_WR : sdram_pkg::C_RD;
				ST_PREA: next_cmd.cmd = sdram_pkg::C_PREA;
				default: next_cmd.cmd = sdram_pkg::C_NOP;
			endcase
			if (st == ST_LOWP && preq == sdram_pkg::PW_NONE) next_cmd.cmd = sdram_pkg::C_EXIT;
			// one rank selected per access, both for rank-wide commands
			if (st == ST_PRE || st == ST_ACT || st == ST_RW) next_cmd.cs_n = cur_cs ? 2'b01 : 2'b10;
			else if (next_cmd.cmd != sdram_pkg::C_NOP) next_cmd.cs_n = 2'b00;
			next_cmd.bank = cur_bank;
			next_cmd.addr = (st == ST_RW) ? {6'h00, slot_q[cur].addr[sdram_pkg::COL_LSB +: 10]} : cur_row;
			// closed page policy closes the row with the access
			next_cmd.ap = st == ST_RW && r_porten[sdram_pkg::EN_POLICY + 32'(cur)];
		end
		if (st == ST_PREA && go) begin
			// partial array mask rides on the address bits
			next_cmd.addr = {8'h00, r_power[sdram_pkg::POW_MASK +: 8]};
		end
	end

	// low power entry command follows the precharge of all banks
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			MEM_CMD <= '0;
			MEM_CMD.cs_n <= 2'b11;
		end else if (st == ST_LOWP && go && !lowp_in && preq != sdram_pkg::PW_NONE) begin
			MEM_CMD <= next_cmd;
			MEM_CMD.cmd <= preq == sdram_pkg::PW_DPD ? sdram_pkg::C_DPD :
				preq == sdram_pkg::PW_PD ? sdram_pkg::C_PD : sdram_pkg::C_SREF;
			MEM_CMD.cs_n <= 2'b00;
		end else begin
			MEM_CMD <= next_cmd;
		end
	end

	// entry is issued once per stay; the gap after the precharge must not swallow it
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) lowp_in <= 1'b0;
		else if (st != ST_LOWP) lowp_in <= 1'b0;
		else if (go && preq != sdram_pkg::PW_NONE) lowp_in <= 1'b1;
	end

	// state walk: pick, precharge on conflict, activate, access
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st <= ST_IDLE;
			cur <= 3'd0;
			gap <= 4'd0;
		end else if (!go) begin
			gap <= gap - 4'd1;
		end else begin
			case (st)
				ST_IDLE: begin
					if (pw_allowed) begin
						st <= ST_PREA;
					end else if (any) begin
						cur <= sel;
						st <= hit[sel] ? ST_RW :
							bank_open[slot_q[sel].addr[sdram_pkg::CS_BIT]][slot_q[sel].addr[sdram_pkg::BANK_LSB +: 3]]
							? ST_PRE : ST_ACT;
					end
				end
				ST_PRE: begin
					st <= ST_ACT;
					gap <= r_timing[3:0];
				end
				ST_ACT: begin
					st <= ST_RW;
					gap <= r_timing[3:0];
				end
				ST_RW: begin
					st <= ST_IDLE;
					gap <= r_timing[3:0];
				end
				ST_PREA: begin
					st <= ST_LOWP;
					gap <= r_timing[3:0];
				end
				ST_LOWP: begin
					if (preq == sdram_pkg::PW_NONE) begin
						st <= ST_IDLE;
						gap <= r_timing[3:0];
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// open row table follows the issued commands
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bank_open <= '0;
			for (int r = 0; r < 2; r++) for (int b = 0; b < 8; b++) open_row[r][b] <= 16'h0000;
		end else if (go) begin
			if (st == ST_ACT) begin
				bank_open[cur_cs][cur_bank] <= 1'b1;
				open_row[cur_cs][cur_bank] <= cur_row;
			end
			if (st == ST_PRE || (st == ST_RW && next_cmd.ap)) bank_open[cur_cs][cur_bank] <= 1'b0;
			if (st == ST_PREA) bank_open <= '0;
		end
	end

	// weighted turns: a port keeps its turn for weight+1 grants
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rr <= 3'd0;
			wcnt <= 4'd0;
			last_we <= 1'b0;
		end else if (st == ST_RW && go) begin
			last_we <= slot_q[cur].we;
			if (wcnt >= r_weight[4*cur +: 4]) begin
				wcnt <= 4'd0;
				rr <= cur + 3'd1;
			end else begin
				wcnt <= wcnt + 4'd1;
				rr <= cur;
			end
		end
	end

	// slots, write acks at issue, reads wait for tagged return
	wire issue = st == ST_RW && go;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			slot_v <= '0;
			wait_rd <= '0;
			HOST_WACK <= '0;
			HOST_RVALID <= '0;
			HOST_RDATA <= '0;
			for (int i = 0; i < NPORT; i++) slot_q[i] <= '0;
		end else begin
			HOST_WACK <= '0;
			HOST_RVALID <= '0;
			for (int i = 0; i < NPORT; i++) begin
				if (issue && cur == 3'(i)) begin
					slot_v[i] <= 1'b0;
					HOST_WACK[i] <= slot_q[i].we;
					wait_rd[i] <= !slot_q[i].we;
				end
				// fabric requests arrive already in the core clock; crossing sits in front
				if (HOST_VALID[i] && HOST_READY[i]) begin
					slot_v[i] <= 1'b1;
					slot_q[i] <= HOST_REQ[i];
				end
				if (MEM_RVALID && MEM_RTAG == 3'(i) && wait_rd[i]) begin
					wait_rd[i] <= 1'b0;
					HOST_RVALID[i] <= 1'b1;
					HOST_RDATA[i] <= {32'h0000_0000, MEM_RDATA};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// width masking and ecc check bits
	function automatic logic [7:0] ecc_of(input logic [31:0] d, input logic wide);
		logic [7:0] e;
		e = 8'h00;
		for (int b = 0; b < 8; b++) e[b] = ^(d & sdram_pkg::ECC_MASK[b]);
		// 16 data bits take 8 check bits for a 24 bit word
		return wide ? e : {e[7:6], e[5:0] ^ {6{^d[15:0]}}};
	endfunction
	logic [31:0] wmask;
	wire ecc_on = r_ctrl[sdram_pkg::CTRL_ECC] && (wmode == sdram_pkg::W16E || wmode == sdram_pkg::W32E);
	always_comb begin
		case (wmode)
			sdram_pkg::W8: wmask = 32'h0000_00FF;
			sdram_pkg::W16, sdram_pkg::W16E: wmask = 32'h0000_FFFF;
			default: wmask = 32'hFFFF_FFFF;
		endcase
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			MEM_WDATA <= 32'h0000_0000;
			MEM_WECC <= 8'h00;
		end else if (issue && slot_q[cur].we) begin
			MEM_WDATA <= slot_q[cur].wdata[31:0] & wmask;
			MEM_WECC <= ecc_on ? ecc_of(slot_q[cur].wdata[31:0] & wmask, wmode == sdram_pkg::W32E) : 8'h00;
		end
	end
	// sticky ecc mismatch; a new error wins over a clear in the same cycle
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) ecc_err <= 1'b0;
		else if (ecc_on && MEM_RVALID && MEM_RECC != ecc_of(MEM_RDATA & wmask, wmode == sdram_pkg::W32E))
			ecc_err <= 1'b1;
		else if (reg_wr && {aw_addr[7:2], 2'b00} == sdram_pkg::REG_STATUS && w_data[20]) ecc_err <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	chk_full_ready: assert property (@(posedge CORE_CLK) disable iff (RST)
		(slot_v | wait_rd) != '0 |-> (HOST_READY & (slot_v | wait_rd)) == '0)
		else $error("ready while slot busy");
	chk_unassigned_cmd: assert property (@(posedge CORE_CLK) disable iff (RST)
		(HOST_READY & ~r_porten[NPORT-1:0]) == '0) else $error("disabled port ready");
	chk_unassigned_data: assert property (@(posedge CORE_CLK) disable iff (RST)
		(HOST_RVALID & ~$past(wait_rd)) == '0) else $error("read data without request");
	chk_closed_policy: assert property (@(posedge CORE_CLK) disable iff (RST)
		(MEM_CMD.cmd == sdram_pkg::C_RD || MEM_CMD.cmd == sdram_pkg::C_WR) |->
		MEM_CMD.ap == $past(r_porten[sdram_pkg::EN_POLICY + 32'(cur)])) else $error("page policy");
	chk_dpd_type: assert property (@(posedge CORE_CLK) disable iff (RST)
		MEM_CMD.cmd == sdram_pkg::C_DPD |-> MEM_CMD.mtype == sdram_pkg::MEM_LPDDR2)
		else $error("deep power down on wrong type");
	chk_one_rank: assert property (@(posedge CORE_CLK) disable iff (RST)
		(MEM_CMD.cmd == sdram_pkg::C_ACT || MEM_CMD.cmd == sdram_pkg::C_RD) |->
		(MEM_CMD.cs_n == 2'b01 || MEM_CMD.cs_n == 2'b10)) else $error("rank select");
	chk_act_first: assert property (@(posedge CORE_CLK) disable iff (RST)
		MEM_CMD.cmd == sdram_pkg::C_ACT |-> ##[1:16] (MEM_CMD.cmd == sdram_pkg::C_RD ||
		MEM_CMD.cmd == sdram_pkg::C_WR)) else $error("activate not followed by access");
	chk_wack_issue: assert property (@(posedge CORE_CLK) disable iff (RST)
		(issue && slot_q[cur].we) |=> HOST_WACK[$past(cur)]) else $error("write ack missing");
	chk_prio_pick: assert property (@(posedge CORE_CLK) disable iff (RST)
		(st == ST_IDLE && go && any && !pw_allowed) |->
		r_prio[3*sel +: 3] >= r_prio[3*rr +: 3] || !slot_v[rr]) else $error("priority order");
endmodule

// ==== core/sdram_pkg.sv ====
// shared constants, types and register map of the sdram controller
package sdram_pkg;
	localparam int NPORT = 8;
	localparam int NFAB = 6;
	localparam int FAB_BASE = 2;
	localparam int DATA_PORTS = 4;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TIMING = 8'h04;
	localparam logic [7:0] REG_POWER = 8'h08;
	localparam logic [7:0] REG_PORTEN = 8'h0C;
	localparam logic [7:0] REG_PRIO = 8'h10;
	localparam logic [7:0] REG_WEIGHT = 8'h14;
	localparam logic [7:0] REG_FABCFG = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	// reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_0011;
	localparam logic [31:0] RST_TIMING = 32'h0000_0002;
	localparam logic [31:0] RST_PORTEN = 32'h0000_0003;
	// field positions
	localparam int CTRL_WMODE = 2;
	localparam int CTRL_ECC = 5;
	localparam int POW_MASK = 8;
	localparam int EN_POLICY = 8;
	localparam int FAB_ROLE = 12;
	// host word address layout, 64-bit units; 16 row bits reach 4 Gb parts
	localparam int COL_LSB = 0;
	localparam int BANK_LSB = 10;
	localparam int ROW_LSB = 13;
	localparam int CS_BIT = 29;
	// error response code
	localparam logic [1:0] RESP_DECERR = 2'b11;
	// ecc check masks over the low 32 data bits
	localparam logic [31:0] ECC_MASK [8] = '{32'h56AA_AD5B, 32'h9B33_366D,
		32'hE3C3_C78E, 32'h03FC_07F0, 32'h03FF_F800, 32'hFC00_0000,
		32'hFFFF_0000, 32'h0000_FFFF};
	typedef enum logic [1:0] {MEM_DDR2 = 2'b00, MEM_DDR3 = 2'b01, MEM_LPDDR2 = 2'b10} mem_type_t;
	typedef enum logic [2:0] {W8 = 3'b000, W16 = 3'b001, W16E = 3'b010, W32 = 3'b011,
		W32E = 3'b100} wmode_t;
	typedef enum logic [2:0] {PW_NONE = 3'b000, PW_SREF = 3'b001, PW_PASR = 3'b010,
		PW_PD = 3'b011, PW_DPD = 3'b100} pwr_t;
	typedef enum logic [3:0] {C_NOP = 4'h0, C_ACT = 4'h1, C_RD = 4'h2, C_WR = 4'h3,
		C_PRE = 4'h4, C_PREA = 4'h5, C_SREF = 4'h6, C_PD = 4'h7, C_DPD = 4'h8,
		C_EXIT = 4'h9} cmd_t;
	typedef struct packed {
		logic we;
		logic [31:0] addr;
		logic [63:0] wdata;
	} host_req_t;
	typedef struct packed {
		cmd_t cmd;
		mem_type_t mtype;
		logic [1:0] cs_n;
		logic [2:0] bank;
		logic [15:0] addr;
		logic ap;
		logic [2:0] tag;
	} mem_cmd_t;
endpackage

// ==== verification/mem_phy_model.sv ====
// behavioural phy partner that answers read commands with tagged data
`timescale 1ns/1ps
module mem_phy_model (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// command stream from the controller
	input sdram_pkg::mem_cmd_t MEM_CMD,
	// read return toward the controller
	output logic MEM_RVALID,
	output logic [2:0] MEM_RTAG,
	output logic [31:0] MEM_RDATA,
	output logic [7:0] MEM_RECC
);
	logic [1:0] wait_cnt; // edges left until the data beat
	logic [2:0] tag_hold; // tag of the pending read
	// fixed read latency; outside the beat the lines toggle so stale data never looks valid
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			wait_cnt <= 2'h0;
			tag_hold <= 3'h0;
			MEM_RVALID <= 1'b0;
			MEM_RTAG <= 3'h0;
			MEM_RDATA <= 32'h0000_0000;
		end else begin
			MEM_RVALID <= 1'b0;
			MEM_RTAG <= ~MEM_RTAG;
			MEM_RDATA <= ~MEM_RDATA;
			if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
			// data carries its tag so a port mix-up shows in the read data
			if (wait_cnt == 2'h1) begin
				MEM_RVALID <= 1'b1;
				MEM_RTAG <= tag_hold;
				MEM_RDATA <= {16'hA5C3, 13'h0000, tag_hold};
			end
			if (MEM_CMD.cmd == sdram_pkg::C_RD) begin
				wait_cnt <= 2'h3;
				tag_hold <= MEM_CMD.tag;
			end
		end
	end
	// check bits match the full 32-bit data, so an ecc-enabled controller sees a clean word in 32e mode only
	always_comb begin
		for (int i = 0; i < 8; i++) MEM_RECC[i] = ^(MEM_RDATA & sdram_pkg::ECC_MASK[i]);
	end
endmodule

// ==== verification/soc_sdram_controller_host_ports_bench.sv ====
// self-checking bench for the multiport sdram controller
`timescale 1ns/1ps
module soc_sdram_controller_host_ports_bench;
	logic clk = 1'b0, rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] host_valid = 8'h00, host_ready, host_wack, host_rvalid;
	sdram_pkg::host_req_t [7:0] host_req = '0;
	logic [7:0][63:0] host_rdata;
	sdram_pkg::mem_cmd_t mem_cmd, seen_cmd;
	logic [31:0] mem_wdata, mem_rdata, seen_wd, rd32;
	logic [7:0] mem_wecc, mem_recc, seen_ecc;
	logic mem_rvalid, found;
	logic [2:0] mem_rtag;
	logic [1:0] rsp;
	logic [63:0] seen_rd;
	int err_count = 0, comparisons = 0;
	always #2.5 clk = ~clk; // 200 MHz
	sdram_ctrl uut (.CORE_CLK(clk), .RST(rst), .S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready),
		.S_WDATA(wdata), .S_WSTRB(4'hF), .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp),
		.S_BVALID(bvalid), .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready),
		.S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready), .HOST_VALID(host_valid),
		.HOST_REQ(host_req), .HOST_READY(host_ready), .HOST_WACK(host_wack), .HOST_RVALID(host_rvalid),
		.HOST_RDATA(host_rdata), .MEM_CMD(mem_cmd), .MEM_WDATA(mem_wdata), .MEM_WECC(mem_wecc),
		.MEM_RVALID(mem_rvalid), .MEM_RTAG(mem_rtag), .MEM_RDATA(mem_rdata), .MEM_RECC(mem_recc));
	mem_phy_model phy (.CORE_CLK(clk), .RST(rst), .MEM_CMD(mem_cmd), .MEM_RVALID(mem_rvalid),
		.MEM_RTAG(mem_rtag), .MEM_RDATA(mem_rdata), .MEM_RECC(mem_recc));
	////////////////////////////////////////////////////////////////////////////////
	// one compare for every kind of result, widened to 64 bits
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// axi4-lite write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h2;
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (n < 100) begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				n = 1000;
			end
		end
		if (n < 1000) chk(1, 0); // no write response
	endtask
	// axi4-lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (n < 100) begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				n = 1000;
			end
		end
		if (n < 1000) chk(1, 0); // no read response
	endtask
	// one host transfer; records the memory command and the answer it produced
	task automatic host_op(input int p, input logic we, input logic [31:0] a, input logic [63:0] d);
		int n;
		logic got, done;
		n = 0; got = 0; done = 0;
		host_valid[p] <= 1'b1;
		host_req[p] <= '{we: we, addr: a, wdata: d};
		while (!(done && got) && n < 300) begin
			@(posedge clk);
			n++;
			if (host_valid[p] && host_ready[p]) host_valid[p] <= 1'b0;
			if (!got && mem_cmd.cmd === (we ? sdram_pkg::C_WR : sdram_pkg::C_RD)) begin
				got = 1; seen_cmd = mem_cmd; seen_wd = mem_wdata; seen_ecc = mem_wecc;
			end
			if (we ? host_wack[p] === 1'b1 : host_rvalid[p] === 1'b1) begin
				done = 1; seen_rd = host_rdata[p];
			end
		end
		chk(done && got, 1);
	endtask
	// watch the command bus for one command kind over a bounded span
	task automatic wait_cmd(input sdram_pkg::cmd_t c, input int lim);
		found = 0;
		for (int i = 0; i < lim && !found; i++) begin
			@(posedge clk);
			if (mem_cmd.cmd === c) begin found = 1; seen_cmd = mem_cmd; end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reset values, read-back, unmapped offsets
	task automatic test_regs();
		axi_rd(sdram_pkg::REG_CTRL, rd32, rsp); chk(rd32, sdram_pkg::RST_CTRL);
		axi_rd(sdram_pkg::REG_PORTEN, rd32, rsp); chk(rd32, sdram_pkg::RST_PORTEN);
		axi_wr(sdram_pkg::REG_TIMING, 32'h0000_0005, rsp); chk(rsp, 0);
		axi_rd(sdram_pkg::REG_TIMING, rd32, rsp); chk(rd32, 32'h0000_0005);
		axi_wr(8'h20, 32'hFFFF_0000, rsp); chk(rsp, sdram_pkg::RESP_DECERR);
		axi_rd(8'h20, rd32, rsp); chk({rsp, rd32}, {sdram_pkg::RESP_DECERR, 32'h0000_0000});
		axi_wr(sdram_pkg::REG_TIMING, 32'h0000_0002, rsp);
	endtask
	// interconnect port writes; low word reaches memory masked by width mode
	task automatic test_write();
		logic [7:0] ex;
		host_op(1, 1'b1, 32'h0000_0C02, 64'h1111_2222_DEAD_BEEF);
		chk(seen_wd, 32'hDEAD_BEEF);
		chk({seen_cmd.bank, seen_cmd.cs_n}, {3'h3, 2'b10});
		axi_wr(sdram_pkg::REG_CTRL, 32'h0000_0001, rsp);
		host_op(1, 1'b1, 32'h0000_0C03, 64'h1111_2222_DEAD_BEEF);
		chk(seen_wd, 32'h0000_00EF);
		axi_wr(sdram_pkg::REG_CTRL, 32'h0000_0031, rsp);
		host_op(1, 1'b1, 32'h0000_0C03, 64'h1111_2222_DEAD_BEEF);
		for (int b = 0; b < 8; b++) ex[b] = ^(32'hDEAD_BEEF & sdram_pkg::ECC_MASK[b]);
		chk(seen_ecc, ex);
		axi_wr(sdram_pkg::REG_CTRL, sdram_pkg::RST_CTRL, rsp);
	endtask
	// processor port read from the second rank, data returned by tag
	task automatic test_read();
		host_op(0, 1'b0, 32'h2000_F404, 64'h0);
		chk({seen_cmd.bank, seen_cmd.cs_n}, {3'h5, 2'b01});
		chk(seen_rd, 64'h0000_0000_A5C3_0000);
	endtask
	// fabric port refuses while unassigned, serves once enabled
	task automatic test_idle();
		host_valid[2] <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			chk(host_ready[2], 0);
		end
		host_valid[2] <= 1'b0;
		axi_wr(sdram_pkg::REG_PORTEN, 32'h0000_0407, rsp);
		host_op(2, 1'b1, 32'h0000_0040, 64'h0000_0000_1234_5678);
		chk(seen_cmd.ap, 1);
		chk(seen_wd, 32'h1234_5678);
	endtask
	// low-power entry and exit; deep power-down only for lpddr2
	task automatic test_power();
		sdram_pkg::cmd_t want [4] = '{sdram_pkg::C_SREF, sdram_pkg::C_PREA, sdram_pkg::C_PD, sdram_pkg::C_DPD};
		logic [31:0] code [4] = '{32'h0000_0001, 32'h0000_5A02, 32'h0000_0003, 32'h0000_0004};
		fork axi_wr(sdram_pkg::REG_POWER, 32'h0000_0004, rsp); wait_cmd(sdram_pkg::C_DPD, 60); join
		chk(found, 0);
		axi_wr(sdram_pkg::REG_POWER, 32'h0000_0000, rsp);
		repeat (10) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			if (i == 3) axi_wr(sdram_pkg::REG_CTRL, 32'h0000_000E, rsp);
			fork axi_wr(sdram_pkg::REG_POWER, code[i], rsp); wait_cmd(want[i], 100); join
			chk(found, 1);
			if (i == 1) chk(seen_cmd.addr, 16'h005A);
			if (i == 3) chk(seen_cmd.mtype, sdram_pkg::MEM_LPDDR2);
			fork axi_wr(sdram_pkg::REG_POWER, 32'h0000_0000, rsp); wait_cmd(sdram_pkg::C_EXIT, 100); join
			chk(found, 1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic final_report();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		test_regs();
		test_write();
		test_read();
		test_idle();
		test_power();
		final_report();
	end
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		err_count++;
		final_report();
	end
endmodule
